/* rtl/startup_mode_select.sv */
// startup operation mode selector: start mode at reset and gated mode switching
// assumes terminal inputs and panel key are synchronous, active high, debounced
`include "startup_mode_consts.svh"
`default_nettype none
module startup_mode_select #(
	parameter int SEL_W = `SEL_W,
	parameter int STARTUP_W = `STARTUP_W
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic setting_write_i,
	input wire logic [SEL_W-1:0] mode_selection_setting_i,
	input wire logic [STARTUP_W-1:0] startup_selection_setting_i,
	input wire logic motor_running_i,
	input wire logic output_stop_input_i,
	input wire logic network_external_switch_input_i,
	input wire logic panel_network_switch_input_i,
	input wire logic external_panel_switch_input_i,
	input wire logic panel_mode_key_i,
	input wire logic [1:0] mode_request_i,
	input wire logic mode_request_valid_i,
	input wire logic remote_write_i,
	input wire logic remote_run_i,
	output logic [1:0] op_mode_o,
	output logic switch_refused_o,
	output logic setting_refused_o,
	output logic remote_write_accept_o,
	output logic remote_run_accept_o
);
	if (SEL_W < 3 || STARTUP_W < 4) begin : g_bad_width
		$error("setting widths too narrow for codes");
	end

	typedef startup_mode_pkg::op_mode_e mode_t;

	logic [SEL_W-1:0] mode_sel;
	logic [STARTUP_W-1:0] start_sel;

	mode_settings_latch #(.SEL_W(SEL_W), .STARTUP_W(STARTUP_W)) u_mode_settings_latch (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.write_i(setting_write_i),
		.motor_running_i(motor_running_i),
		.mode_selection_setting_i(mode_selection_setting_i),
		.startup_selection_setting_i(startup_selection_setting_i),
		.mode_selection_o(mode_sel),
		.startup_selection_o(start_sel),
		.write_refused_o(setting_refused_o)
	);

	// startup 10 counts only for modes 0, 2, 6; others behave as startup 0
	function automatic logic is_panel_net_start(input logic [STARTUP_W-1:0] s, input logic [SEL_W-1:0] m);
		is_panel_net_start = (s == STARTUP_W'(`START_PANEL_NET)) &&
			(m == SEL_W'(`SEL_EXT_PANEL_NET) || m == SEL_W'(`SEL_EXT_NET) || m == SEL_W'(`SEL_RUN_SWITCH));
	endfunction

	function automatic logic is_combined(input logic [SEL_W-1:0] m);
		is_combined = (m == SEL_W'(`SEL_COMBINED_A)) || (m == SEL_W'(`SEL_COMBINED_B));
	endfunction

	// start mode from settings and the output-stop level
	function automatic mode_t start_mode(input logic [STARTUP_W-1:0] s, input logic [SEL_W-1:0] m,
			input logic stop_in);
		start_mode = startup_mode_pkg::MODE_EXTERNAL;
		if (m == SEL_W'(`SEL_PANEL_FIXED)) begin
			start_mode = startup_mode_pkg::MODE_PANEL;
		end else if (is_combined(m)) begin
			start_mode = startup_mode_pkg::MODE_COMBINED;
		end else if (m == SEL_W'(`SEL_STOP_GATED)) begin
			if (s == STARTUP_W'(`START_NETWORK) && stop_in)
				start_mode = startup_mode_pkg::MODE_NETWORK;
		end else if (s == STARTUP_W'(`START_NETWORK) || is_panel_net_start(s, m)) begin
			start_mode = startup_mode_pkg::MODE_NETWORK;
		end
	endfunction

	typedef struct packed {
		logic started;
		logic [1:0] mode;
		logic refused;
		logic key_prev;
		logic pn_prev;
		logic ne_prev;
		logic ep_prev;
		logic wr_acc;
		logic run_acc;
	} sel_s;

	sel_s state;
	sel_s next_state;

	always_comb begin
		logic fixed;
		logic run_ok;
		logic pn_mode;
		logic want;
		mode_t target;
		fixed = 1'b0;
		run_ok = 1'b0;
		pn_mode = 1'b0;
		want = 1'b0;
		target = mode_t'(state.mode);
		next_state = state;
		next_state.refused = 1'b0;
		next_state.key_prev = panel_mode_key_i;
		next_state.pn_prev = panel_network_switch_input_i;
		next_state.ne_prev = network_external_switch_input_i;
		next_state.ep_prev = external_panel_switch_input_i;
		pn_mode = is_panel_net_start(start_sel, mode_sel);
		fixed = (mode_sel == SEL_W'(`SEL_PANEL_FIXED)) || is_combined(mode_sel) ||
			(pn_mode && mode_sel == SEL_W'(`SEL_EXT_NET));
		run_ok = (mode_sel == SEL_W'(`SEL_RUN_SWITCH));
		if (!state.started) begin
			next_state.started = 1'b1;
			next_state.mode = start_mode(start_sel, mode_sel, output_stop_input_i);
		end else if (mode_sel == SEL_W'(`SEL_STOP_GATED) && !output_stop_input_i) begin
			next_state.mode = startup_mode_pkg::MODE_EXTERNAL;
		end else if (fixed) begin
			next_state.mode = start_mode(start_sel, mode_sel, output_stop_input_i);
			next_state.refused = mode_request_valid_i;
		end else if (!motor_running_i || run_ok) begin
			// edge-triggered so a held input does not fight a panel request
			if (!pn_mode && network_external_switch_input_i != state.ne_prev) begin
				want = 1'b1;
				// mode 2 never offers panel, so a falling net/ext input always lands in external
				target = network_external_switch_input_i ? startup_mode_pkg::MODE_NETWORK
					: ((external_panel_switch_input_i || mode_sel == SEL_W'(`SEL_EXT_NET))
					? startup_mode_pkg::MODE_EXTERNAL
					: startup_mode_pkg::MODE_PANEL);
			end else if (pn_mode && panel_network_switch_input_i != state.pn_prev) begin
				want = 1'b1;
				target = panel_network_switch_input_i ? startup_mode_pkg::MODE_PANEL
					: startup_mode_pkg::MODE_NETWORK;
			end else if (pn_mode && panel_mode_key_i && !state.key_prev) begin
				want = 1'b1;
				target = (state.mode == startup_mode_pkg::MODE_PANEL) ? startup_mode_pkg::MODE_NETWORK
					: startup_mode_pkg::MODE_PANEL;
			end else if (!pn_mode && external_panel_switch_input_i != state.ep_prev
					&& state.mode != startup_mode_pkg::MODE_NETWORK) begin
				want = 1'b1;
				target = external_panel_switch_input_i ? startup_mode_pkg::MODE_EXTERNAL
					: startup_mode_pkg::MODE_PANEL;
			end else if (mode_request_valid_i) begin
				want = 1'b1;
				target = mode_t'(mode_request_i);
			end
			if (want) begin
				if (target == startup_mode_pkg::MODE_COMBINED) begin
					next_state.refused = 1'b1;
				end else if (!pn_mode && mode_sel == SEL_W'(`SEL_EXT_NET)
						&& target == startup_mode_pkg::MODE_PANEL) begin
					next_state.refused = 1'b1;
				end else if (pn_mode && target == startup_mode_pkg::MODE_EXTERNAL) begin
					next_state.refused = 1'b1;
				end else if (!pn_mode && ((state.mode == startup_mode_pkg::MODE_PANEL
						&& target == startup_mode_pkg::MODE_NETWORK)
						|| (state.mode == startup_mode_pkg::MODE_NETWORK
						&& target == startup_mode_pkg::MODE_PANEL))) begin
					next_state.refused = 1'b1;
				end else begin
					next_state.mode = target;
				end
			end
		end else if (mode_request_valid_i) begin
			next_state.refused = 1'b1;
		end
		next_state.wr_acc = remote_write_i && next_state.mode == startup_mode_pkg::MODE_NETWORK;
		next_state.run_acc = remote_run_i && next_state.mode == startup_mode_pkg::MODE_NETWORK;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= '0;
		end else if (clk_en_i) begin
			state <= next_state;
		end
	end

	assign op_mode_o = state.mode;
	assign switch_refused_o = state.refused;
	assign remote_write_accept_o = state.wr_acc;
	assign remote_run_accept_o = state.run_acc;

	sequence s_started;
		state.started;
	endsequence

	property p_stop_forces_ext;
		@(posedge clk_sys_i) disable iff (reset_i)
		(clk_en_i && mode_sel == SEL_W'(`SEL_STOP_GATED) && !output_stop_input_i && !setting_write_i)
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_EXTERNAL));
	endproperty
	a_stop_forces_ext: assert property (p_stop_forces_ext) else $error("mode 7 not external");

	property p_panel_fixed;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_started ##0 (clk_en_i && mode_sel == SEL_W'(`SEL_PANEL_FIXED) && !setting_write_i)
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_PANEL));
	endproperty
	a_panel_fixed: assert property (p_panel_fixed) else $error("mode 1 not panel");

	property p_combined_fixed;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_started ##0 (clk_en_i && is_combined(mode_sel) && !setting_write_i)
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_COMBINED));
	endproperty
	a_combined_fixed: assert property (p_combined_fixed) else $error("combined mode left");

	property p_no_pn_direct;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state.started && !pn_ok() && op_mode_o == 2'(startup_mode_pkg::MODE_PANEL) && !setting_write_i
		&& mode_sel != SEL_W'(`SEL_STOP_GATED)) |=> (op_mode_o != 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_no_pn_direct: assert property (p_no_pn_direct) else $error("direct panel to network");

	function automatic logic pn_ok();
		pn_ok = is_panel_net_start(start_sel, mode_sel) || !clk_en_i;
	endfunction

	property p_startup;
		@(posedge clk_sys_i) disable iff (reset_i)
		(clk_en_i && !state.started) |=> (op_mode_o == 2'(start_mode(start_sel, mode_sel, $past(output_stop_input_i))));
	endproperty
	a_startup: assert property (p_startup) else $error("wrong start mode");

	property p_remote;
		@(posedge clk_sys_i) disable iff (reset_i)
		remote_write_accept_o |-> (op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_remote: assert property (p_remote) else $error("remote write outside network");

	property p_net_ext_fixed;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state.started && clk_en_i && pn_ok() && mode_sel == SEL_W'(`SEL_EXT_NET) && !setting_write_i)
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_net_ext_fixed: assert property (p_net_ext_fixed) else $error("startup 10 mode 2 not network");

	property p_no_panel_mode2;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state.started && clk_en_i && !is_panel_net_start(start_sel, mode_sel) && mode_sel == SEL_W'(`SEL_EXT_NET)
		&& op_mode_o != 2'(startup_mode_pkg::MODE_PANEL) && !setting_write_i)
		|=> (op_mode_o != 2'(startup_mode_pkg::MODE_PANEL));
	endproperty
	a_no_panel_mode2: assert property (p_no_panel_mode2) else $error("panel entered under mode 2");

	sequence s_settled;
		state.started && clk_en_i && !setting_write_i;
	endsequence

	sequence s_pn_steady;
		panel_network_switch_input_i == state.pn_prev;
	endsequence

	property p_running_refused;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (motor_running_i && mode_request_valid_i && !pn_ok() && mode_sel == SEL_W'(`SEL_EXT_PANEL_NET))
		|=> (switch_refused_o && $stable(op_mode_o));
	endproperty
	a_running_refused: assert property (p_running_refused) else $error("switch taken while running");

	property p_combined_refused;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (is_combined(mode_sel) && mode_request_valid_i) |=> switch_refused_o;
	endproperty
	a_combined_refused: assert property (p_combined_refused) else $error("combined request not refused");

	property p_ne_rise_net;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (!motor_running_i && !pn_ok() && mode_sel == SEL_W'(`SEL_EXT_NET)
		&& network_external_switch_input_i && !state.ne_prev && op_mode_o != 2'(startup_mode_pkg::MODE_PANEL))
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_ne_rise_net: assert property (p_ne_rise_net) else $error("net/ext input on not network");

	property p_ne_fall_ext;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (!motor_running_i && !pn_ok() && mode_sel == SEL_W'(`SEL_EXT_NET)
		&& !network_external_switch_input_i && state.ne_prev && op_mode_o != 2'(startup_mode_pkg::MODE_PANEL))
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_EXTERNAL));
	endproperty
	a_ne_fall_ext: assert property (p_ne_fall_ext) else $error("net/ext input off not external");

	property p_pn_on_panel;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (!motor_running_i && pn_ok() && mode_sel == SEL_W'(`SEL_EXT_PANEL_NET)
		&& panel_network_switch_input_i && !state.pn_prev) |=> (op_mode_o == 2'(startup_mode_pkg::MODE_PANEL));
	endproperty
	a_pn_on_panel: assert property (p_pn_on_panel) else $error("panel/net input on not panel");

	property p_pn_off_net;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 (!motor_running_i && pn_ok() && mode_sel == SEL_W'(`SEL_EXT_PANEL_NET)
		&& !panel_network_switch_input_i && state.pn_prev) |=> (op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_pn_off_net: assert property (p_pn_off_net) else $error("panel/net input off not network");

	property p_key_toggle;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 s_pn_steady ##0 (pn_ok() && mode_sel == SEL_W'(`SEL_RUN_SWITCH) && panel_mode_key_i
		&& !state.key_prev && op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK))
		|=> (op_mode_o == 2'(startup_mode_pkg::MODE_PANEL));
	endproperty
	a_key_toggle: assert property (p_key_toggle) else $error("panel key did not toggle");

	property p_ext_refused_pn;
		@(posedge clk_sys_i) disable iff (reset_i)
		s_settled ##0 s_pn_steady ##0 (!motor_running_i && pn_ok() && mode_sel == SEL_W'(`SEL_EXT_PANEL_NET)
		&& mode_request_valid_i && mode_request_i == 2'(startup_mode_pkg::MODE_EXTERNAL)
		&& !(panel_mode_key_i && !state.key_prev)) |=> switch_refused_o;
	endproperty
	a_ext_refused_pn: assert property (p_ext_refused_pn) else $error("external taken under startup 10");

	property p_remote_run;
		@(posedge clk_sys_i) disable iff (reset_i)
		remote_run_accept_o |-> (op_mode_o == 2'(startup_mode_pkg::MODE_NETWORK));
	endproperty
	a_remote_run: assert property (p_remote_run) else $error("remote run outside network");
endmodule // startup_mode_select
`default_nettype wire

/* rtl/startup_mode_consts.svh */
// constants for the startup operation mode selector: setting codes and encodings
// assumes settings arrive as plain parallel words held stable by software
// Summary of operation
// - pick start mode at power-on, restore, reset
// - startup 0, mode 0: external, switching while stopped
// - no direct panel to network change outside startup 10
// - mode 1: panel mode, fixed
// - mode 2: external, net switch, never panel
// - mode 3 or 4: combined, no changes
// - mode 6: switching allowed while running
// - mode 7, stop inactive: force external
// - startup 1: network start; mode 7 by stop
// - startup 10, mode 0: network, panel/net switching
// - startup 10, mode 6: same while running
// - startup 10, mode 2: network, fixed
// - startup 10: key or switch input changes
// - setting changes only while motor stopped
// - network mode accepts remote writes, runs
// - priority: mode, stop, net/ext, panel/net, ext/panel, startup
// - panel/net input on panel, off network
`ifndef STARTUP_MODE_CONSTS_SVH
`define STARTUP_MODE_CONSTS_SVH
`define SEL_W 4
`define STARTUP_W 4
`define SEL_EXT_PANEL_NET 4'h0
`define SEL_PANEL_FIXED 4'h1
`define SEL_EXT_NET 4'h2
`define SEL_COMBINED_A 4'h3
`define SEL_COMBINED_B 4'h4
`define SEL_RUN_SWITCH 4'h6
`define SEL_STOP_GATED 4'h7
`define START_AS_MODE 4'h0
`define START_NETWORK 4'h1
`define START_PANEL_NET 4'hA
`define MODE_SELECTION_RESET 4'h0
`define STARTUP_SELECTION_RESET 4'h0
`endif

/* rtl/startup_mode_pkg.sv */
// types shared by the startup operation mode selector
// assumes nothing of its surroundings
`default_nettype none
package startup_mode_pkg;
	typedef enum logic [1:0] {
		MODE_EXTERNAL,
		MODE_PANEL,
		MODE_NETWORK,
		MODE_COMBINED
	} op_mode_e;
endpackage
`default_nettype wire

/* rtl/mode_settings_latch.sv */
// holds the live mode and startup settings; accepts new values only at motor stop
// assumes write strobe and data synchronous to clk_sys_i
`include "startup_mode_consts.svh"
`default_nettype none
module mode_settings_latch #(
	parameter int SEL_W = `SEL_W,
	parameter int STARTUP_W = `STARTUP_W
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic write_i,
	input wire logic motor_running_i,
	input wire logic [SEL_W-1:0] mode_selection_setting_i,
	input wire logic [STARTUP_W-1:0] startup_selection_setting_i,
	output logic [SEL_W-1:0] mode_selection_o,
	output logic [STARTUP_W-1:0] startup_selection_o,
	output logic write_refused_o
);
	if (SEL_W < 3 || STARTUP_W < 4) begin : g_bad_width
		$error("setting widths too narrow for codes");
	end

	typedef struct packed {
		logic [SEL_W-1:0] mode_sel;
		logic [STARTUP_W-1:0] start_sel;
		logic refused;
	} latch_s;

	latch_s state;
	latch_s next_state;

	always_comb begin
		next_state = state;
		next_state.refused = 1'b0;
		if (write_i) begin
			if (!motor_running_i) begin
				next_state.mode_sel = mode_selection_setting_i;
				next_state.start_sel = startup_selection_setting_i;
			end else begin
				next_state.refused = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state.mode_sel <= SEL_W'(`MODE_SELECTION_RESET);
			state.start_sel <= STARTUP_W'(`STARTUP_SELECTION_RESET);
			state.refused <= 1'b0;
		end else if (clk_en_i) begin
			state <= next_state;
		end
	end

	assign mode_selection_o = state.mode_sel;
	assign startup_selection_o = state.start_sel;
	assign write_refused_o = state.refused;

	property p_no_change_running;
		@(posedge clk_sys_i) disable iff (reset_i)
		(clk_en_i && write_i && motor_running_i) |=> ($stable(mode_selection_o) && write_refused_o);
	endproperty
	a_no_change_running: assert property (p_no_change_running) else $error("setting changed while running");
endmodule // mode_settings_latch
`default_nettype wire

/* tb/terminal_panel_model.sv */
// far side model: terminal switch levels and the operation panel key
// assumes the bench calls its task from the clk_sys_i domain; all levels idle low
`default_nettype none
module terminal_panel_model (
	input wire logic clk_sys_i,
	output logic output_stop_input_o,
	output logic network_external_switch_input_o,
	output logic panel_network_switch_input_o,
	output logic external_panel_switch_input_o,
	output logic panel_mode_key_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		output_stop_input_o = 1'b0;
		network_external_switch_input_o = 1'b0;
		panel_network_switch_input_o = 1'b0;
		external_panel_switch_input_o = 1'b0;
		panel_mode_key_o = 1'b0;
	end
	// a level changes just after an edge and then holds, as a debounced terminal would
	task automatic set_level(input int which, input logic v);
		@(posedge clk_sys_i);
		case (which)
			0: output_stop_input_o <= v;
			1: network_external_switch_input_o <= v;
			2: panel_network_switch_input_o <= v;
			3: external_panel_switch_input_o <= v;
			default: panel_mode_key_o <= v;
		endcase
	endtask
endmodule // terminal_panel_model
`default_nettype wire

/* tb/startup_mode_select_test.sv */
// self-checking bench for the startup operation mode selector
// assumes the terminal/panel model drives every switch input and the panel key
`include "startup_mode_consts.svh"
`default_nettype none
module startup_mode_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] EXT = startup_mode_pkg::MODE_EXTERNAL;
	localparam logic [1:0] PNL = startup_mode_pkg::MODE_PANEL;
	localparam logic [1:0] NETWORK_OPERATION_MODE = startup_mode_pkg::MODE_NETWORK;
	localparam logic [1:0] CMB = startup_mode_pkg::MODE_COMBINED;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, setting_write_i = 1'b0, motor_running_i = 1'b0;
	logic mode_request_valid_i = 1'b0, remote_write_i = 1'b0, remote_run_i = 1'b0, clk_en_i = 1'b1;
	logic [3:0] mode_selection_setting_i = 4'h0, startup_selection_setting_i = 4'h0;
	logic [1:0] mode_request_i = 2'h0, op_mode_o;
	logic stop_w, net_ext_w, panel_net_w, ext_panel_w, key_w;
	logic switch_refused_o, setting_refused_o, remote_write_accept_o, remote_run_accept_o;
	int ref_cnt = 0, set_cnt = 0, wa_cnt = 0, ra_cnt = 0, miscompares = 0, compares = 0;
	logic [7:0] got;
	initial forever #5 clk_sys_i = ~clk_sys_i;
	// pulses counted mid-cycle so the tasks never race the counters
	always @(negedge clk_sys_i) begin
		if (switch_refused_o === 1'b1) ref_cnt++;
		if (setting_refused_o === 1'b1) set_cnt++;
		if (remote_write_accept_o === 1'b1) wa_cnt++;
		if (remote_run_accept_o === 1'b1) ra_cnt++;
	end
	startup_mode_select u_startup_mode_select (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.setting_write_i(setting_write_i), .mode_selection_setting_i(mode_selection_setting_i),
		.startup_selection_setting_i(startup_selection_setting_i), .motor_running_i(motor_running_i),
		.output_stop_input_i(stop_w), .network_external_switch_input_i(net_ext_w),
		.panel_network_switch_input_i(panel_net_w), .external_panel_switch_input_i(ext_panel_w),
		.panel_mode_key_i(key_w), .mode_request_i(mode_request_i), .mode_request_valid_i(mode_request_valid_i),
		.remote_write_i(remote_write_i), .remote_run_i(remote_run_i), .op_mode_o(op_mode_o),
		.switch_refused_o(switch_refused_o), .setting_refused_o(setting_refused_o),
		.remote_write_accept_o(remote_write_accept_o), .remote_run_accept_o(remote_run_accept_o));
	terminal_panel_model u_terminal_panel_model (.clk_sys_i(clk_sys_i), .output_stop_input_o(stop_w),
		.network_external_switch_input_o(net_ext_w), .panel_network_switch_input_o(panel_net_w),
		.external_panel_switch_input_o(ext_panel_w), .panel_mode_key_o(key_w));
	function automatic logic [7:0] ex(input int n, input logic [1:0] m);
		return {4'(n), 2'h0, m};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic idle();
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic req(input logic [1:0] m);
		int base;
		base = ref_cnt;
		@(posedge clk_sys_i);
		mode_request_i <= m;
		mode_request_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		mode_request_valid_i <= 1'b0;
		idle();
		got = ex(ref_cnt - base, op_mode_o);
	endtask
	task automatic wr(input logic [3:0] m, input logic [3:0] s);
		int base;
		base = set_cnt;
		@(posedge clk_sys_i);
		mode_selection_setting_i <= m;
		startup_selection_setting_i <= s;
		setting_write_i <= 1'b1;
		@(posedge clk_sys_i);
		setting_write_i <= 1'b0;
		idle();
		got = ex(set_cnt - base, op_mode_o);
	endtask
	task automatic remote();
		int wb, rb;
		wb = wa_cnt;
		rb = ra_cnt;
		@(posedge clk_sys_i);
		remote_write_i <= 1'b1;
		remote_run_i <= 1'b1;
		@(posedge clk_sys_i);
		remote_write_i <= 1'b0;
		remote_run_i <= 1'b0;
		idle();
		got = {4'(wa_cnt - wb), 4'(ra_cnt - rb)};
	endtask
	// which 4 is a full press and release of the panel key
	task automatic term(input int which, input logic v);
		u_terminal_panel_model.set_level(which, v);
		if (which == 4) u_terminal_panel_model.set_level(4, 1'b0);
		idle();
		got = ex(0, op_mode_o);
	endtask
	task automatic motor(input logic v);
		@(posedge clk_sys_i);
		motor_running_i <= v;
	endtask
	task automatic t_start_and_switch();
		remote();
		check(got, 8'h00);
		req(NETWORK_OPERATION_MODE);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		remote();
		check(got, 8'h11);
		req(PNL);
		check(got, ex(1, NETWORK_OPERATION_MODE));
		req(EXT);
		check(got, ex(0, EXT));
		req(PNL);
		check(got, ex(0, PNL));
		req(NETWORK_OPERATION_MODE);
		check(got, ex(1, PNL));
		req(EXT);
		check(got, ex(0, EXT));
		$display("test start_and_switch done");
	endtask
	// a request made while frozen must leave no trace once the enable returns
	task automatic t_freeze();
		@(posedge clk_sys_i);
		clk_en_i <= 1'b0;
		req(NETWORK_OPERATION_MODE);
		check(got, ex(0, EXT));
		@(posedge clk_sys_i);
		clk_en_i <= 1'b1;
		idle();
		got = ex(0, op_mode_o);
		check(got, ex(0, EXT));
		$display("test freeze done");
	endtask
	task automatic t_running();
		motor(1'b1);
		req(NETWORK_OPERATION_MODE);
		check(got, ex(1, EXT));
		wr(`SEL_RUN_SWITCH, `START_AS_MODE);
		check(got, ex(1, EXT));
		motor(1'b0);
		wr(`SEL_RUN_SWITCH, `START_AS_MODE);
		check(got, ex(0, EXT));
		motor(1'b1);
		req(NETWORK_OPERATION_MODE);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		req(EXT);
		check(got, ex(0, EXT));
		motor(1'b0);
		$display("test running done");
	endtask
	task automatic t_ext_net_and_stop();
		wr(`SEL_EXT_NET, `START_AS_MODE);
		req(PNL);
		check(got, ex(1, EXT));
		req(NETWORK_OPERATION_MODE);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		req(EXT);
		check(got, ex(0, EXT));
		term(1, 1'b1);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		term(1, 1'b0);
		check(got, ex(0, EXT));
		wr(`SEL_STOP_GATED, `START_AS_MODE);
		req(NETWORK_OPERATION_MODE);
		check(got & 8'h03, ex(0, EXT));
		term(0, 1'b1);
		req(NETWORK_OPERATION_MODE);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		term(0, 1'b0);
		check(got, ex(0, EXT));
		$display("test ext_net_and_stop done");
	endtask
	task automatic t_panel_net();
		wr(`SEL_EXT_PANEL_NET, `START_PANEL_NET);
		term(2, 1'b1);
		check(got, ex(0, PNL));
		term(2, 1'b0);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		term(4, 1'b1);
		check(got, ex(0, PNL));
		term(4, 1'b1);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		req(EXT);
		check(got, ex(1, NETWORK_OPERATION_MODE));
		wr(`SEL_EXT_NET, `START_PANEL_NET);
		check(got, ex(0, NETWORK_OPERATION_MODE));
		req(PNL);
		check(got, ex(1, NETWORK_OPERATION_MODE));
		wr(`SEL_RUN_SWITCH, `START_PANEL_NET);
		motor(1'b1);
		term(4, 1'b1);
		check(got, ex(0, PNL));
		motor(1'b0);
		$display("test panel_net done");
	endtask
	task automatic t_fixed();
		wr(`SEL_PANEL_FIXED, `START_AS_MODE);
		check(got, ex(0, PNL));
		req(EXT);
		check(got, ex(1, PNL));
		wr(`SEL_PANEL_FIXED, `START_PANEL_NET);
		check(got, ex(0, PNL));
		wr(`SEL_COMBINED_A, `START_AS_MODE);
		check(got, ex(0, CMB));
		req(NETWORK_OPERATION_MODE);
		check(got, ex(1, CMB));
		wr(`SEL_COMBINED_B, `START_PANEL_NET);
		check(got, ex(0, CMB));
		req(EXT);
		check(got, ex(1, CMB));
		$display("test fixed done");
	endtask
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		idle();
		t_start_and_switch();
		t_freeze();
		t_running();
		t_ext_net_and_stop();
		t_panel_net();
		t_fixed();
		summarize();
	end
endmodule // startup_mode_select_test
`default_nettype wire
